// >>> hdl/bst_tap.sv
// Function
// - Four test inputs and one serial output drive a TAP state machine stepped by clock, mode select and reset.
// - A sixteen-bit instruction register is shifted in during instruction scans.
// - All scan registers share serial input and the output is muxed from the register being scanned.
// - Outside test modes the boundary register passes pin signals unchanged.
// - In external test the boundary register breaks all normal pin paths, in clamp only the output paths.
// - Every test register shifts out least significant bit first.
// - External test drives and senses the pins from boundary register contents.
// - Sample/preload captures pin and core values while normal operation continues.
// - Bypass routes serial input to output through one cell.
// - Identification selects the ID register for shifting out.
// - High-impedance instruction stops every device output driving except serial test data out.
// - Clamp holds pins from the boundary register with bypass as the serial path.
// - The float strap low floats all outputs except serial test data out.
`timescale 1ns/10ps
`default_nettype none
module bst_tap (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic test_logic_reset_in_n,
  input wire logic device_float_strap_n,
  input wire logic [bst_pkg::N_IN-1:0] pin_in,
  input wire logic [bst_pkg::N_OUT-1:0] core_out,
  input wire logic [bst_pkg::N_OUT-1:0] core_oe,
  output logic tdo,
  output logic tdo_oe,
  output logic [bst_pkg::N_IN-1:0] core_in,
  output logic [bst_pkg::N_OUT-1:0] pin_out,
  output logic [bst_pkg::N_OUT-1:0] pin_oe
);

  localparam int NI = bst_pkg::N_IN;
  localparam int NO = bst_pkg::N_OUT;
  localparam int BW = bst_pkg::BSR_W;
  localparam int DL = bst_pkg::BSR_DAT_LO;
  localparam int EL = bst_pkg::BSR_EN_LO;

  bst_pkg::bst_pins_t sync1_q, sync2_q;
  logic tck_prev_q;
  bst_pkg::bst_state_t state_q, state_d;
  logic [15:0] ir_shift_q, ir_shift_d, ir_q, ir_d;
  logic [31:0] id_q, id_d;
  logic bypass_q, bypass_d;
  logic [BW-1:0] bsr_shift, bsr_upd, bsr_cap, chain_in;
  bst_pkg::bst_ctl_t bsr_ctl;
  logic tdo_d, tdo_oe_d;
  logic [NO-1:0] pin_out_d, pin_oe_d;
  logic [NI-1:0] core_in_d;

  // ==========================================================
  // Pin synchroniser and test clock edges
  // Test clock is oversampled; inputs share the same two-flop delay so
  // mode select and data stay aligned with the sampled clock edge.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_q <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1, float_n: 1'b1, pin_in: '0};
      sync2_q <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1, float_n: 1'b1, pin_in: '0};
      tck_prev_q <= 1'b0;
    end else begin
      sync1_q <= '{tck: tck, tms: tms, tdi: tdi, trst_n: test_logic_reset_in_n,
                   float_n: device_float_strap_n, pin_in: pin_in};
      sync2_q <= sync1_q;
      tck_prev_q <= sync2_q.tck;
    end
  end

  wire logic tck_rise = sync2_q.tck & ~tck_prev_q;
  wire logic tck_fall = ~sync2_q.tck & tck_prev_q;
  wire logic trst_act = ~sync2_q.trst_n;
  wire logic tms_s = sync2_q.tms;
  wire logic tdi_s = sync2_q.tdi;

  // ==========================================================
  // TAP state machine
  always_comb begin
    case (state_q)
      bst_pkg::ST_TLR: state_d = tms_s ? bst_pkg::ST_TLR : bst_pkg::ST_RTI;
      bst_pkg::ST_RTI: state_d = tms_s ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
      bst_pkg::ST_SEL_DR: state_d = tms_s ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
      bst_pkg::ST_CAP_DR: state_d = tms_s ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_SH_DR: state_d = tms_s ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_EX1_DR: state_d = tms_s ? bst_pkg::ST_UP_DR : bst_pkg::ST_PA_DR;
      bst_pkg::ST_PA_DR: state_d = tms_s ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PA_DR;
      bst_pkg::ST_EX2_DR: state_d = tms_s ? bst_pkg::ST_UP_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_UP_DR: state_d = tms_s ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
      bst_pkg::ST_SEL_IR: state_d = tms_s ? bst_pkg::ST_TLR : bst_pkg::ST_CAP_IR;
      bst_pkg::ST_CAP_IR: state_d = tms_s ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_SH_IR: state_d = tms_s ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_EX1_IR: state_d = tms_s ? bst_pkg::ST_UP_IR : bst_pkg::ST_PA_IR;
      bst_pkg::ST_PA_IR: state_d = tms_s ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PA_IR;
      bst_pkg::ST_EX2_IR: state_d = tms_s ? bst_pkg::ST_UP_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_UP_IR: state_d = tms_s ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
      default: state_d = bst_pkg::ST_TLR;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= bst_pkg::ST_TLR;
    end else if (trst_act) begin
      state_q <= bst_pkg::ST_TLR;
    end else if (tck_rise) begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Instruction register and decode
  wire logic rise_cap_ir = tck_rise & (state_q == bst_pkg::ST_CAP_IR);
  wire logic rise_sh_ir = tck_rise & (state_q == bst_pkg::ST_SH_IR);
  wire logic rise_up_ir = tck_rise & (state_q == bst_pkg::ST_UP_IR);
  wire logic in_tlr = state_q == bst_pkg::ST_TLR;

  assign ir_shift_d = rise_cap_ir ? bst_pkg::IR_CAPTURE :
                      rise_sh_ir ? {tdi_s, ir_shift_q[15:1]} : ir_shift_q;
  assign ir_d = in_tlr ? bst_pkg::IR_RESET : (rise_up_ir ? ir_shift_q : ir_q);

  wire logic op_extest = ir_q == bst_pkg::OP_EXTEST;
  wire logic op_sample = ir_q == bst_pkg::OP_SAMPLE;
  wire logic op_idcode = ir_q == bst_pkg::OP_IDCODE;
  wire logic op_highz = ir_q == bst_pkg::OP_HIGHZ;
  wire logic op_clamp = ir_q == bst_pkg::OP_CLAMP;
  // Unknown codes fall back to bypass, as do clamp and high-impedance
  wire logic sel_bsr = op_extest | op_sample;
  wire logic sel_bypass = ~(sel_bsr | op_idcode);
  wire logic pins_held = op_extest | op_clamp;

  // ==========================================================
  // Data registers
  wire logic rise_cap_dr = tck_rise & (state_q == bst_pkg::ST_CAP_DR);
  wire logic rise_sh_dr = tck_rise & (state_q == bst_pkg::ST_SH_DR);
  wire logic rise_up_dr = tck_rise & (state_q == bst_pkg::ST_UP_DR);

  assign id_d = (rise_cap_dr & op_idcode) ? bst_pkg::ID_VALUE :
                (rise_sh_dr & op_idcode) ? {tdi_s, id_q[31:1]} : id_q;
  assign bypass_d = (rise_cap_dr & sel_bypass) ? 1'b0 :
                    (rise_sh_dr & sel_bypass) ? tdi_s : bypass_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ir_shift_q <= '0;
      ir_q <= bst_pkg::IR_RESET;
      id_q <= '0;
      bypass_q <= 1'b0;
    end else begin
      ir_shift_q <= ir_shift_d;
      ir_q <= ir_d;
      id_q <= id_d;
      bypass_q <= bypass_d;
    end
  end

  // ==========================================================
  // Boundary register chain, cell 0 nearest serial out
  assign bsr_ctl = '{capture: rise_cap_dr & sel_bsr, shift: rise_sh_dr & sel_bsr,
                     update: rise_up_dr & sel_bsr};
  assign bsr_cap = {core_oe, core_out, sync2_q.pin_in};
  assign chain_in = {tdi_s, bsr_shift[BW-1:1]};

  genvar gi;
  generate
    for (gi = 0; gi < BW; gi = gi + 1) begin : g_cell
      bst_cell u_cell (
        .clk_sys(clk_sys),
        .rst(rst),
        .ctl(bsr_ctl),
        .capture_val(bsr_cap[gi]),
        .shift_in(chain_in[gi]),
        .shift_q(bsr_shift[gi]),
        .update_q(bsr_upd[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Serial output, changed on the falling test clock edge
  wire logic in_sh_ir = state_q == bst_pkg::ST_SH_IR;
  wire logic in_sh_dr = state_q == bst_pkg::ST_SH_DR;
  wire logic dr_bit = op_idcode ? id_q[0] : (sel_bsr ? bsr_shift[0] : bypass_q);
  assign tdo_d = tck_fall ? (in_sh_ir ? ir_shift_q[0] : dr_bit) : tdo;
  assign tdo_oe_d = tck_fall ? (in_sh_ir | in_sh_dr) : tdo_oe;

  // ==========================================================
  // Pin paths
  // One clk_sys of latency on the functional path buys flop-driven pins.
  assign pin_out_d = pins_held ? bsr_upd[EL-1:DL] : core_out;
  assign pin_oe_d = (~sync2_q.float_n | op_highz) ? '0 :
                    (pins_held ? bsr_upd[BW-1:EL] : core_oe);
  assign core_in_d = op_extest ? bsr_upd[NI-1:0] : sync2_q.pin_in;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
      pin_out <= '0;
      pin_oe <= '0;
      core_in <= '0;
    end else begin
      tdo <= tdo_d;
      tdo_oe <= tdo_oe_d;
      pin_out <= pin_out_d;
      pin_oe <= pin_oe_d;
      core_in <= core_in_d;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence ir_load_s;
    tck_rise && (state_q == bst_pkg::ST_UP_IR) && !trst_act;
  endsequence

  sequence id_capture_s;
    tck_rise && (state_q == bst_pkg::ST_CAP_DR) && op_idcode;
  endsequence

  trst_to_tlr_a: assert property (trst_act |=> state_q == bst_pkg::ST_TLR)
    else $error("test reset did not reach test-logic-reset");
  tlr_ir_reset_a: assert property (in_tlr |=> ir_q == bst_pkg::IR_RESET)
    else $error("instruction not reset to identification");
  ir_update_a: assert property (ir_load_s |=> ir_q == $past(ir_shift_q))
    else $error("instruction update lost");
  ir_shift_in_a: assert property (rise_sh_ir |=> ir_shift_q[15] == $past(tdi_s))
    else $error("instruction shift wrong");
  id_lsb_one_a: assert property (id_capture_s |=> id_q == bst_pkg::ID_VALUE && id_q[0])
    else $error("identification capture wrong");
  id_lsb_first_a: assert property (tck_fall && in_sh_dr && op_idcode |=> tdo == $past(id_q[0]))
    else $error("identification not shifted lsb first");
  bypass_cell_a: assert property (rise_sh_dr && sel_bypass ##1 !tck_fall [*2] |-> bypass_q == $past(tdi_s, 2))
    else $error("bypass cell not one stage");
  highz_float_a: assert property (op_highz |=> pin_oe == '0)
    else $error("outputs driven in high impedance");
  strap_float_a: assert property (!sync2_q.float_n |=> pin_oe == '0 && ($stable(tdo_oe) || $past(tck_fall)))
    else $error("strap did not float outputs");
  normal_pass_a: assert property (!pins_held |=> pin_out == $past(core_out))
    else $error("functional output path broken");
  extest_drive_a: assert property (pins_held |=> pin_out == $past(bsr_upd[EL-1:DL]))
    else $error("held pins not from boundary register");
  sample_cap_a: assert property (bsr_ctl.capture |=> bsr_shift[NI-1:0] == $past(sync2_q.pin_in))
    else $error("pin sample not captured");

endmodule
`default_nettype wire

// >>> hdl/bst_pkg.sv
package bst_pkg;

  // ==========================================================
  // Sizes
  localparam int IR_W = 16;
  localparam int ID_W = 32;
  localparam int N_IN = 4;
  localparam int N_OUT = 4;
  localparam int BSR_W = N_IN + 2 * N_OUT;
  localparam int BSR_DAT_LO = N_IN;
  localparam int BSR_EN_LO = N_IN + N_OUT;

  // ==========================================================
  // Instruction codes
  localparam logic [15:0] OP_EXTEST = 16'h0000;
  localparam logic [15:0] OP_SAMPLE = 16'h0001;
  localparam logic [15:0] OP_IDCODE = 16'h0002;
  localparam logic [15:0] OP_HIGHZ = 16'h0003;
  localparam logic [15:0] OP_CLAMP = 16'h0004;
  localparam logic [15:0] OP_BYPASS = 16'hffff;
  localparam logic [15:0] IR_RESET = OP_IDCODE;
  localparam logic [15:0] IR_CAPTURE = 16'h0001;
  // Arbitrary identity value, bit 0 must stay one
  localparam logic [31:0] ID_VALUE = 32'h0a5a_5001;

  // ==========================================================
  // Types
  typedef enum logic [15:0] {
    ST_TLR = 16'h0001,
    ST_RTI = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PA_DR = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UP_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PA_IR = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UP_IR = 16'h8000
  } bst_state_t;

  typedef struct packed {
    logic capture;
    logic shift;
    logic update;
  } bst_ctl_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
    logic float_n;
    logic [N_IN-1:0] pin_in;
  } bst_pins_t;

endpackage

// >>> hdl/bst_cell.sv
`timescale 1ns/10ps
`default_nettype none
module bst_cell (
  input wire logic clk_sys,
  input wire logic rst,
  input wire bst_pkg::bst_ctl_t ctl,
  input wire logic capture_val,
  input wire logic shift_in,
  output logic shift_q,
  output logic update_q
);

  logic shift_d;
  logic update_d;

  // ==========================================================
  // Capture, shift, update stages
  assign shift_d = ctl.capture ? capture_val : (ctl.shift ? shift_in : shift_q);
  assign update_d = ctl.update ? shift_q : update_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shift_q <= 1'b0;
      update_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      update_q <= update_d;
    end
  end

endmodule
`default_nettype wire

// >>> verification/bst_ctl_model.sv
`timescale 1ns/10ps
`default_nettype none
module bst_ctl_model (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // ==========
  // Test bus controller, clock idles low between frames
  logic oe_all;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b0;
    oe_all = 1'b1;
  end
  task automatic trst(input logic v);
    trst_n = v;
  endtask
  // Data out is taken at the rising edge, long after its update
  // Undriven data out reads inverted, so a missing enable shows up
  task automatic tick(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #40;
    tck = 1'b1;
    o = tdo_oe ? tdo : ~tdo;
    #40;
    tck = 1'b0;
  endtask
  task automatic walk(input logic [7:0] path, input int n);
    logic o;
    for (int i = 0; i < n; i++) begin
      tick(path[i], 1'b0, o);
    end
  endtask
  task automatic shift(input logic [63:0] din, input int n, output logic [63:0] dout);
    logic o;
    dout = '0;
    oe_all = 1'b1;
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
      oe_all = oe_all & tdo_oe;
    end
    walk(8'h01, 2);
  endtask
  task automatic idle();
    walk(8'h1f, 6);
  endtask
  task automatic ir(input logic [15:0] op, output logic [63:0] cap);
    walk(8'h03, 4);
    shift({48'h0, op}, 16, cap);
  endtask
  task automatic dr(input logic [63:0] din, input int n, output logic [63:0] dout);
    walk(8'h01, 3);
    shift(din, n, dout);
  endtask
endmodule
`default_nettype wire

// >>> verification/test_boundary_scan_tap.sv
`timescale 1ns/10ps
`default_nettype none
module test_boundary_scan_tap;
  logic clk_sys, rst, tck, tms, tdi, trst_n, strap_n, tdo, tdo_oe;
  logic [bst_pkg::N_IN-1:0] pin_in, core_in;
  logic [bst_pkg::N_OUT-1:0] core_out, core_oe, pin_out, pin_oe;
  logic [63:0] got;
  int errors, checked;
  bst_tap dut (.clk_sys(clk_sys), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .test_logic_reset_in_n(trst_n), .device_float_strap_n(strap_n), .pin_in(pin_in),
    .core_out(core_out), .core_oe(core_oe), .tdo(tdo), .tdo_oe(tdo_oe),
    .core_in(core_in), .pin_out(pin_out), .pin_oe(pin_oe));
  bst_ctl_model u_ctl (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe));
  // ==========
  // Clock and helpers
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic settle();
    repeat (6) @(posedge clk_sys);
    #1;
  endtask
  task automatic test_done();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_id();
    u_ctl.idle();
    u_ctl.dr(64'h0, 32, got);
    chk(got, {32'h0, bst_pkg::ID_VALUE});
    chk({63'h0, u_ctl.oe_all}, 64'h1);
    chk({63'h0, tdo_oe}, 64'h0);
    u_ctl.ir(bst_pkg::OP_IDCODE, got);
    chk(got, {48'h0, bst_pkg::IR_CAPTURE});
    u_ctl.dr(64'hffff_ffff, 32, got);
    chk(got, {32'h0, bst_pkg::ID_VALUE});
    $display("t_id done");
  endtask
  task automatic t_bypass();
    logic [15:0] ops [2];
    ops[0] = bst_pkg::OP_BYPASS;
    ops[1] = 16'h0123;
    for (int i = 0; i < 2; i++) begin
      u_ctl.ir(ops[i], got);
      u_ctl.dr(64'hb5, 8, got);
      chk(got, 64'h6a);
    end
    core_out = 4'ha;
    settle();
    chk({60'h0, pin_out}, 64'ha);
    $display("t_bypass done");
  endtask
  task automatic t_sample();
    pin_in = 4'h9;
    core_out = 4'h6;
    core_oe = 4'hc;
    settle();
    chk({52'h0, pin_oe, pin_out, core_in}, 64'hc69);
    u_ctl.ir(bst_pkg::OP_SAMPLE, got);
    u_ctl.dr(64'h5a3, 12, got);
    chk(got, 64'hc69);
    chk({56'h0, pin_oe, pin_out}, 64'hc6);
    $display("t_sample done");
  endtask
  task automatic t_extest();
    u_ctl.ir(bst_pkg::OP_EXTEST, got);
    core_out = 4'h1;
    settle();
    chk({52'h0, pin_oe, pin_out, core_in}, 64'h5a3);
    u_ctl.dr(64'h5a3, 12, got);
    chk(got, 64'hc19);
    $display("t_extest done");
  endtask
  task automatic t_clamp();
    u_ctl.ir(bst_pkg::OP_CLAMP, got);
    u_ctl.dr(64'h0f, 4, got);
    chk(got, 64'he);
    chk({56'h0, pin_oe, pin_out}, 64'h5a);
    $display("t_clamp done");
  endtask
  task automatic t_highz();
    u_ctl.ir(bst_pkg::OP_HIGHZ, got);
    settle();
    chk({60'h0, pin_oe}, 64'h0);
    $display("t_highz done");
  endtask
  task automatic t_strap();
    u_ctl.trst(1'b0);
    settle();
    u_ctl.trst(1'b1);
    settle();
    chk({52'h0, pin_oe, pin_out, core_in}, 64'hc19);
    strap_n = 1'b0;
    settle();
    chk({60'h0, pin_oe}, 64'h0);
    u_ctl.idle();
    u_ctl.dr(64'h0, 32, got);
    chk(got, {32'h0, bst_pkg::ID_VALUE});
    chk({63'h0, u_ctl.oe_all}, 64'h1);
    strap_n = 1'b1;
    $display("t_strap done");
  endtask
  // ==========
  // Main sequence and watchdog
  initial begin
    errors = 0;
    checked = 0;
    rst = 1'b1;
    strap_n = 1'b1;
    pin_in = '0;
    core_out = '0;
    core_oe = '0;
    repeat (10) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    settle();
    u_ctl.trst(1'b1);
    t_id();
    t_bypass();
    t_sample();
    t_extest();
    t_clamp();
    t_highz();
    t_strap();
    test_done();
  end
  // About 28 us of scans expected
  initial begin
    #300000;
    errors++;
    test_done();
  end
endmodule
`default_nettype wire
